/* design/durs_regsel.v */
// Purpose: Register select and access gating for one channel of a dual UART
// Assumes: Strobes active low, synchronous to clock_in; one access per strobe
// Notes:   Reads return data one clock after the strobe falls; writes take effect on the strobe's first cycle
`timescale 1ns/1ps
`include "durs_map.vh"
module durs_regsel (
    input  wire       clock_in,
    input  wire       rst_b_in,
    input  wire [2:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       rd_b_in,
    input  wire       wr_b_in,
    input  wire       chan_sel_b_in,
    input  wire       channel_a_select_b_in,
    input  wire       channel_b_select_b_in,
    input  wire [7:0] rx_holding_in,
    input  wire [7:0] irq_ident_in,
    input  wire [7:0] line_status_in,
    input  wire [7:0] modem_status_in,
    input  wire [1:0] rx_ready_in,
    input  wire [1:0] tx_ready_in,
    output reg  [7:0] rdata_out,
    output reg        tx_holding_we_out,
    output reg  [7:0] tx_holding_out,
    output reg        rx_holding_re_out,
    output reg        fifo_control_we_out,
    output reg  [7:0] fifo_control_out,
    output reg  [7:0] irq_enable_out,
    output reg  [7:0] line_control_out,
    output reg  [7:0] modem_control_out,
    output reg  [15:0] divisor_out,
    output reg  [7:0] enhanced_features_out,
    output reg  [7:0] resume_char_one_out,
    output reg  [7:0] resume_char_two_out,
    output reg  [7:0] pause_char_one_out,
    output reg  [7:0] pause_char_two_out,
    output reg  [7:0] flow_threshold_out,
    output reg  [7:0] fifo_trigger_level_out
);
    // Register selector codes
    localparam SEL_NONE    = 4'h0;
    localparam SEL_DATA    = 4'h1;
    localparam SEL_IRQ_EN  = 4'h2;
    localparam SEL_IDENT   = 4'h3;
    localparam SEL_LCR     = 4'h4;
    localparam SEL_MCR     = 4'h5;
    localparam SEL_LSR     = 4'h6;
    localparam SEL_MSR     = 4'h7;
    localparam SEL_SCRATCH = 4'h8;
    localparam SEL_DIV_LO  = 4'h9;
    localparam SEL_DIV_HI  = 4'ha;
    localparam SEL_EFR     = 4'hb;
    localparam SEL_RESUME_CHAR_ONE    = 4'hc;
    localparam SEL_RESUME_CHAR_TWO    = 4'hd;
    localparam SEL_PAUSE_CHAR_ONE   = 4'he;
    localparam SEL_PAUSE_CHAR_TWO   = 4'hf;

    // Held registers
    reg  [7:0] ier_q;          // Interrupt enable
    reg  [7:0] fcr_q;          // Last FIFO control value
    reg  [7:0] lcr_q;          // Line control
    reg  [7:0] mcr_q;          // Modem control
    reg  [7:0] scratch_q;      // Scratch byte
    reg  [7:0] div_lo_q;       // Divisor low byte
    reg  [7:0] div_hi_q;       // Divisor bits 15..8
    reg  [7:0] efr_q;          // Enhanced features
    reg  [7:0] flow_char_q [0:3]; // Resume one, two, pause one, two
    reg  [7:0] thresh_q;       // Flow threshold
    reg  [7:0] trig_q;         // FIFO trigger level
    reg        rd_prev_q;      // Read strobe last cycle, for edge
    reg        wr_prev_q;      // Write strobe last cycle, for edge

    // Decoded access conditions
    wire       enh_en      = efr_q[`DURS_BIT_ENH_EN];
    wire       div_access  = lcr_q[`DURS_BIT_DIV_ACC];
    wire       enh_set     = (lcr_q == `DURS_ENH_KEY);
    wire       thr_access  = enh_en & mcr_q[`DURS_BIT_THR_ACC];
    wire       rdy_access  = ~channel_a_select_b_in & ~channel_b_select_b_in &
                             mcr_q[`DURS_BIT_RDY_EN] & ~mcr_q[`DURS_BIT_LOOP];
    wire       rd_pulse    = ~chan_sel_b_in & ~rd_b_in & rd_prev_q;
    wire       wr_pulse    = ~chan_sel_b_in & ~wr_b_in & wr_prev_q;
    wire       rdy_read    = rdy_access & (addr_in == `DURS_OFF_SCRATCH);
    wire [7:0] rdy_summary = {2'h0, rx_ready_in, 2'h0, tx_ready_in};

    // Guarded write values
    wire [7:0] ier_wr;
    wire [7:0] fcr_wr;
    wire [7:0] mcr_wr;

    reg  [3:0] sel;            // Chosen normal/enhanced/divisor register
    reg        sel_thresh;     // Flow threshold chosen
    reg        sel_trig;       // Trigger level chosen

    // Protect enhanced bits of interrupt enable
    durs_guard u_ier_guard (
        .old_in     (ier_q),
        .new_in     (wdata_in),
        .mask_in    (`DURS_MASK_IER_ENH),
        .enh_in     (enh_en),
        .merged_out (ier_wr)
    );
    // Transmit trigger field is an enhanced function
    durs_guard u_fcr_guard (
        .old_in     (fcr_q),
        .new_in     (wdata_in),
        .mask_in    (`DURS_MASK_FCR_ENH),
        .enh_in     (enh_en),
        .merged_out (fcr_wr)
    );
    // Prescaler and other enhanced modem control bits
    durs_guard u_mcr_guard (
        .old_in     (mcr_q),
        .new_in     (wdata_in),
        .mask_in    (`DURS_MASK_MCR_ENH),
        .enh_in     (enh_en),
        .merged_out (mcr_wr)
    );

    // Address decode with precedence; ready summary handled at read mux
    always @* begin
        sel_thresh = 1'b0;
        sel_trig   = 1'b0;
        sel        = SEL_NONE;
        if (thr_access && addr_in == `DURS_OFF_MODEM_STS) begin
            sel_thresh = 1'b1;
        end else if (thr_access && addr_in == `DURS_OFF_SCRATCH) begin
            sel_trig = 1'b1;
        end else if (enh_set && addr_in != `DURS_OFF_DATA && addr_in != `DURS_OFF_IRQ_EN
                     && addr_in != `DURS_OFF_LINE_CTL) begin
            case (addr_in)
                `DURS_OFF_IDENT:     sel = SEL_EFR;
                `DURS_OFF_MODEM_CTL: sel = SEL_RESUME_CHAR_ONE;
                `DURS_OFF_LINE_STS:  sel = SEL_RESUME_CHAR_TWO;
                `DURS_OFF_MODEM_STS: sel = SEL_PAUSE_CHAR_ONE;
                default:             sel = SEL_PAUSE_CHAR_TWO;
            endcase
        end else if (div_access && addr_in == `DURS_OFF_DATA) begin
            sel = SEL_DIV_LO;
        end else if (div_access && addr_in == `DURS_OFF_IRQ_EN) begin
            sel = SEL_DIV_HI;
        end else begin
            // Normal set
            case (addr_in)
                `DURS_OFF_DATA:      sel = SEL_DATA;
                `DURS_OFF_IRQ_EN:    sel = SEL_IRQ_EN;
                `DURS_OFF_IDENT:     sel = SEL_IDENT;
                `DURS_OFF_LINE_CTL:  sel = SEL_LCR;
                `DURS_OFF_MODEM_CTL: sel = SEL_MCR;
                `DURS_OFF_LINE_STS:  sel = SEL_LSR;
                `DURS_OFF_MODEM_STS: sel = SEL_MSR;
                default:             sel = SEL_SCRATCH;
            endcase
        end
    end

    // Register writes and strobe edge tracking
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ier_q          <= `DURS_RST_BYTE;
            fcr_q          <= `DURS_RST_BYTE;
            lcr_q          <= `DURS_RST_LINE_CTL;
            mcr_q          <= `DURS_RST_MODEM_CTL;
            scratch_q      <= `DURS_RST_BYTE;
            div_lo_q       <= `DURS_RST_DIV_LOW;
            div_hi_q       <= `DURS_RST_BYTE;
            efr_q          <= `DURS_RST_BYTE;
            flow_char_q[0] <= `DURS_RST_BYTE;
            flow_char_q[1] <= `DURS_RST_BYTE;
            flow_char_q[2] <= `DURS_RST_BYTE;
            flow_char_q[3] <= `DURS_RST_BYTE;
            thresh_q       <= `DURS_RST_BYTE;
            trig_q         <= `DURS_RST_BYTE;
            rd_prev_q      <= 1'b1;
            wr_prev_q      <= 1'b1;
        end else begin
            rd_prev_q <= rd_b_in;
            wr_prev_q <= wr_b_in;
            if (wr_pulse) begin
                if (sel_thresh) begin
                    thresh_q <= wdata_in;
                end else if (sel_trig) begin
                    trig_q <= wdata_in;
                end else begin
                    case (sel)
                        SEL_IRQ_EN:  ier_q <= ier_wr;
                        SEL_IDENT:   fcr_q <= fcr_wr;
                        SEL_LCR:     lcr_q <= wdata_in;
                        SEL_MCR:     mcr_q <= mcr_wr;
                        SEL_SCRATCH: scratch_q <= wdata_in;
                        SEL_DIV_LO:  div_lo_q <= wdata_in;
                        SEL_DIV_HI:  div_hi_q <= wdata_in;
                        SEL_EFR:     efr_q <= wdata_in;
                        SEL_RESUME_CHAR_ONE:    flow_char_q[0] <= wdata_in;
                        SEL_RESUME_CHAR_TWO:    flow_char_q[1] <= wdata_in;
                        SEL_PAUSE_CHAR_ONE:   flow_char_q[2] <= wdata_in;
                        SEL_PAUSE_CHAR_TWO:   flow_char_q[3] <= wdata_in;
                        // Status offsets and data take no stored write
                        default:     ier_q <= ier_q;
                    endcase
                end
            end
        end
    end

    // Read data, strobes and register copies to the channel
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out              <= `DURS_RST_BYTE;
            tx_holding_we_out      <= 1'b0;
            tx_holding_out         <= `DURS_RST_BYTE;
            rx_holding_re_out      <= 1'b0;
            fifo_control_we_out    <= 1'b0;
            fifo_control_out       <= `DURS_RST_BYTE;
            irq_enable_out         <= `DURS_RST_BYTE;
            line_control_out       <= `DURS_RST_LINE_CTL;
            modem_control_out      <= `DURS_RST_MODEM_CTL;
            divisor_out            <= {`DURS_RST_BYTE, `DURS_RST_DIV_LOW};
            enhanced_features_out  <= `DURS_RST_BYTE;
            resume_char_one_out    <= `DURS_RST_BYTE;
            resume_char_two_out    <= `DURS_RST_BYTE;
            pause_char_one_out     <= `DURS_RST_BYTE;
            pause_char_two_out     <= `DURS_RST_BYTE;
            flow_threshold_out     <= `DURS_RST_BYTE;
            fifo_trigger_level_out <= `DURS_RST_BYTE;
        end else begin
            // Single-cycle strobes toward the transmit and receive paths
            tx_holding_we_out   <= wr_pulse & (sel == SEL_DATA) & ~sel_thresh & ~sel_trig;
            rx_holding_re_out   <= rd_pulse & (sel == SEL_DATA) & ~sel_thresh & ~sel_trig & ~rdy_read;
            fifo_control_we_out <= wr_pulse & (sel == SEL_IDENT) & ~sel_thresh & ~sel_trig;
            if (wr_pulse && sel == SEL_DATA && !sel_thresh && !sel_trig) begin
                tx_holding_out <= wdata_in;
            end
            if (wr_pulse && sel == SEL_IDENT && !sel_thresh && !sel_trig) begin
                fifo_control_out <= fcr_wr;
            end
            // Mirrors lag the holding registers by one clock
            irq_enable_out         <= ier_q;
            line_control_out       <= lcr_q;
            modem_control_out      <= mcr_q;
            divisor_out            <= {div_hi_q, div_lo_q};
            enhanced_features_out  <= efr_q;
            resume_char_one_out    <= flow_char_q[0];
            resume_char_two_out    <= flow_char_q[1];
            pause_char_one_out     <= flow_char_q[2];
            pause_char_two_out     <= flow_char_q[3];
            flow_threshold_out     <= thresh_q;
            fifo_trigger_level_out <= trig_q;
            // Read mux, captured on the strobe's falling edge
            if (rd_pulse) begin
                if (rdy_read) begin
                    rdata_out <= rdy_summary;
                end else if (sel_thresh) begin
                    rdata_out <= thresh_q;
                end else if (sel_trig) begin
                    rdata_out <= trig_q;
                end else begin
                    case (sel)
                        SEL_DATA:    rdata_out <= rx_holding_in;
                        SEL_IRQ_EN:  rdata_out <= ier_q;
                        SEL_IDENT:   rdata_out <= irq_ident_in;
                        SEL_LCR:     rdata_out <= lcr_q;
                        SEL_MCR:     rdata_out <= mcr_q;
                        SEL_LSR:     rdata_out <= line_status_in;
                        SEL_MSR:     rdata_out <= modem_status_in;
                        SEL_SCRATCH: rdata_out <= scratch_q;
                        SEL_DIV_LO:  rdata_out <= div_lo_q;
                        SEL_DIV_HI:  rdata_out <= div_hi_q;
                        SEL_EFR:     rdata_out <= efr_q;
                        SEL_RESUME_CHAR_ONE:    rdata_out <= flow_char_q[0];
                        SEL_RESUME_CHAR_TWO:    rdata_out <= flow_char_q[1];
                        SEL_PAUSE_CHAR_ONE:   rdata_out <= flow_char_q[2];
                        SEL_PAUSE_CHAR_TWO:   rdata_out <= flow_char_q[3];
                        default:     rdata_out <= `DURS_RST_BYTE;
                    endcase
                end
            end
        end
    end
endmodule

/* design/durs_map.vh */
// Purpose: Offsets, fields and reset values of the channel register select block
// Assumes: Three address lines, 8-bit data
// Notes:   Definitions only
`ifndef DURS_MAP_VH
`define DURS_MAP_VH
`define DURS_OFF_DATA      3'h0
`define DURS_OFF_IRQ_EN    3'h1
`define DURS_OFF_IDENT     3'h2
`define DURS_OFF_LINE_CTL  3'h3
`define DURS_OFF_MODEM_CTL 3'h4
`define DURS_OFF_LINE_STS  3'h5
`define DURS_OFF_MODEM_STS 3'h6
`define DURS_OFF_SCRATCH   3'h7
`define DURS_ENH_KEY       8'hbf
`define DURS_BIT_DIV_ACC   7
`define DURS_BIT_ENH_EN    4
`define DURS_BIT_THR_ACC   6
`define DURS_BIT_RDY_EN    2
`define DURS_BIT_LOOP      4
`define DURS_BIT_PRESCALE  7
`define DURS_MASK_IER_ENH  8'hf0
`define DURS_MASK_FCR_ENH  8'h30
`define DURS_MASK_MCR_ENH  8'he0
`define DURS_RST_LINE_CTL  8'h00
`define DURS_RST_MODEM_CTL 8'h00
`define DURS_RST_BYTE      8'h00
`define DURS_RST_DIV_LOW   8'h01
`endif

/* design/durs_guard.v */
// Purpose: Merge a written byte with protected enhanced bits
// Assumes: Mask marks the bits that need the enhanced enable
// Notes:   Pure combinational helper
`timescale 1ns/1ps
module durs_guard (
    input  wire [7:0] old_in,
    input  wire [7:0] new_in,
    input  wire [7:0] mask_in,
    input  wire       enh_in,
    output wire [7:0] merged_out
);
    // Protected bits keep their old value unless enhanced mode is on
    assign merged_out = enh_in ? new_in : ((new_in & ~mask_in) | (old_in & mask_in));
endmodule

/* sim/durs_regsel_asserts.sv */
// Purpose: Port checks for the channel register select block
// Assumes: Mirror outputs settle before the next access starts
// Notes:   Attached by the bind after the module
`timescale 1ns/1ps
module durs_regsel_asserts (
    input wire        clock_in,
    input wire        rst_b_in,
    input wire [2:0]  addr_in,
    input wire [7:0]  wdata_in,
    input wire        rd_b_in,
    input wire        wr_b_in,
    input wire        chan_sel_b_in,
    input wire        channel_a_select_b_in,
    input wire        channel_b_select_b_in,
    input wire [7:0]  rx_holding_in,
    input wire [7:0]  line_status_in,
    input wire [1:0]  rx_ready_in,
    input wire [1:0]  tx_ready_in,
    input wire [7:0]  rdata_out,
    input wire        tx_holding_we_out,
    input wire [7:0]  tx_holding_out,
    input wire        rx_holding_re_out,
    input wire        fifo_control_we_out,
    input wire [7:0]  fifo_control_out,
    input wire [7:0]  line_control_out,
    input wire [7:0]  modem_control_out,
    input wire [15:0] divisor_out,
    input wire [7:0]  enhanced_features_out
);
    reg  rd_q;                                          // Read strobe at last edge
    reg  wr_q;                                          // Write strobe at last edge
    wire tk_rd = !rd_b_in && rd_q && !chan_sel_b_in;    // Read taken this edge
    wire tk_wr = !wr_b_in && wr_q && !chan_sel_b_in;    // Write taken this edge
    wire enh   = line_control_out == 8'hbf;             // Enhanced set open
    // Track strobe history; reset high so a first strobe counts
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_q <= 1'b1;
            wr_q <= 1'b1;
        end else begin
            rd_q <= rd_b_in;
            wr_q <= wr_b_in;
        end
    end
    default clocking dc @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // Data offset reached with divisor access off
    sequence s_rx;
        tk_rd && addr_in == 3'h0 && !line_control_out[7];
    endsequence
    sequence s_tx;
        tk_wr && addr_in == 3'h0 && !line_control_out[7];
    endsequence
    rx_read_a: assert property (s_rx |=> rx_holding_re_out && rdata_out == $past(rx_holding_in))
        else $error("receive read wrong");
    tx_write_a: assert property (s_tx |=> tx_holding_we_out && tx_holding_out == $past(wdata_in))
        else $error("transmit write wrong");
    tx_pulse_a: assert property (tx_holding_we_out |-> $past(tk_wr) && $past(addr_in) == 3'h0)
        else $error("transmit pulse without cause");
    status_read_a: assert property (tk_rd && addr_in == 3'h5 && !enh |=> rdata_out == $past(line_status_in))
        else $error("line status read wrong");
    fcr_guard_a: assert property (tk_wr && addr_in == 3'h2 && !enh |=> fifo_control_we_out
        && fifo_control_out[5:4] == (enhanced_features_out[4] ? $past(wdata_in[5:4]) : $past(fifo_control_out[5:4])))
        else $error("fifo control guard wrong");
    prescale_lock_a: assert property (tk_wr && addr_in == 3'h4 && !enh && !enhanced_features_out[4]
        |-> ##2 modem_control_out[7] == $past(modem_control_out[7], 2))
        else $error("prescaler bit changed");
    ready_read_a: assert property (tk_rd && addr_in == 3'h7 && !channel_a_select_b_in && !channel_b_select_b_in
        && modem_control_out[2] && !modem_control_out[4]
        |=> rdata_out == {2'b00, $past(rx_ready_in), 2'b00, $past(tx_ready_in)})
        else $error("ready summary wrong");
    div_high_a: assert property (tk_wr && addr_in == 3'h1 && line_control_out[7] |-> ##2 divisor_out[15:8] == $past(wdata_in, 2))
        else $error("divisor high byte wrong");
    rdata_hold_a: assert property ($changed(rdata_out) |-> $past(tk_rd))
        else $error("read data changed without read");
endmodule
bind durs_regsel durs_regsel_asserts u_durs_regsel_asserts (.clock_in, .rst_b_in, .addr_in, .wdata_in, .rd_b_in,
    .wr_b_in, .chan_sel_b_in, .channel_a_select_b_in, .channel_b_select_b_in, .rx_holding_in, .line_status_in,
    .rx_ready_in, .tx_ready_in, .rdata_out, .tx_holding_we_out, .tx_holding_out, .rx_holding_re_out,
    .fifo_control_we_out, .fifo_control_out, .line_control_out, .modem_control_out, .divisor_out,
    .enhanced_features_out);

/* sim/durs_host.sv */
// Purpose: Host processor on the parallel register bus
// Assumes: Strobe low for three edges, then high for one
// Notes:   Bus lines show inverted values while idle
`timescale 1ns/1ps
module durs_host (
    input  wire       clock_in,
    input  wire [7:0] rdata_in,
    output reg  [2:0] addr_out = 3'h0,
    output reg  [7:0] wdata_out = 8'h00,
    output reg        rd_b_out = 1'b1,
    output reg        wr_b_out = 1'b1,
    output reg        chan_sel_b_out = 1'b1
);
    // One access; idle lines inverted so stale values cannot pass
    task xfer(input wr, input cs_b, input [2:0] a, input [7:0] d, output [7:0] q);
        begin
            @(posedge clock_in);
            addr_out <= a;
            wdata_out <= d;
            chan_sel_b_out <= cs_b;
            rd_b_out <= wr;
            wr_b_out <= !wr;
            @(posedge clock_in);
            @(posedge clock_in);
            #1 q = rdata_in;
            @(posedge clock_in);
            rd_b_out <= 1'b1;
            wr_b_out <= 1'b1;
            chan_sel_b_out <= 1'b1;
            addr_out <= ~a;
            wdata_out <= ~d;
        end
    endtask
endmodule

/* sim/dual_uart_register_select_tb.sv */
// Purpose: Self-checking bench for the channel register select block
// Assumes: Host model drives the register bus
// Notes:   Status inputs carry fixed distinct patterns
`timescale 1ns/1ps
module dual_uart_register_select_tb;
    reg         clock_in = 1'b0;
    reg         rst_b_in = 1'b0;
    reg         sel_a_b = 1'b1;     // Channel A select, high until ready test
    reg         sel_b_b = 1'b1;     // Channel B select
    reg  [7:0]  rq;                 // Data from last host access
    reg  [1:0]  rdy_rx = 2'b10;     // Receive ready levels, bit0 channel A
    wire [2:0]  addr;
    wire [7:0]  wdata, rdata, ctl_o, fcr_o, ier_o, lcr_o, mcr_o, efr_o, r1_o, r2_o, p1_o, p2_o, thr_o, tce_o;
    wire        rd_b, wr_b, cs_b;
    wire [15:0] div_o;
    integer     n_mismatch = 0;
    integer     comparisons = 0;
    integer     i;
    always #5 clock_in = ~clock_in;
    durs_host u_durs_host (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .rd_b_out(rd_b), .wr_b_out(wr_b), .chan_sel_b_out(cs_b));
    durs_regsel u_durs_regsel (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata),
        .rd_b_in(rd_b), .wr_b_in(wr_b), .chan_sel_b_in(cs_b), .channel_a_select_b_in(sel_a_b),
        .channel_b_select_b_in(sel_b_b), .rx_holding_in(8'h5a), .irq_ident_in(8'hc1), .line_status_in(8'h60),
        .modem_status_in(8'hb0), .rx_ready_in(rdy_rx), .tx_ready_in(2'b01), .rdata_out(rdata),
        .tx_holding_we_out(), .tx_holding_out(ctl_o), .rx_holding_re_out(), .fifo_control_we_out(),
        .fifo_control_out(fcr_o), .irq_enable_out(ier_o), .line_control_out(lcr_o), .modem_control_out(mcr_o),
        .divisor_out(div_o), .enhanced_features_out(efr_o), .resume_char_one_out(r1_o),
        .resume_char_two_out(r2_o), .pause_char_one_out(p1_o), .pause_char_two_out(p2_o),
        .flow_threshold_out(tce_o), .fifo_trigger_level_out(thr_o));
    // Compare and count; report at once on a mismatch
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        u_durs_host.xfer(1'b1, 1'b0, a, d, rq);
    endtask
    task rc(input [2:0] a, input [7:0] e, input string nm);
        begin
            u_durs_host.xfer(1'b0, 1'b0, a, 8'h00, rq);
            chk(nm, {8'h00, rq}, {8'h00, e});
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // Watchdog: tests need about 170 cycles
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        conclude;
    end
    initial begin
        repeat (10) @(posedge clock_in);
        rst_b_in <= 1'b1;
        #1 chk("divisor", div_o, 16'h0001);
        chk("line_control", {8'h00, lcr_o}, 16'h0000);
        $display("test reset done");
        wr(3'h7, 8'ha5);
        rc(3'h7, 8'ha5, "scratch");
        wr(3'h1, 8'hff);
        rc(3'h1, 8'h0f, "irq_enable");
        rc(3'h0, 8'h5a, "rx_holding");
        rc(3'h2, 8'hc1, "irq_ident");
        wr(3'h2, 8'hff);
        chk("fifo_control", {8'h00, fcr_o}, 16'h00cf);
        wr(3'h0, 8'h3c);
        chk("tx_holding", {8'h00, ctl_o}, 16'h003c);
        wr(3'h5, 8'h11);
        wr(3'h6, 8'h22);
        rc(3'h5, 8'h60, "line_status");
        rc(3'h6, 8'hb0, "modem_status");
        wr(3'h4, 8'hff);
        rc(3'h4, 8'h1f, "modem_control");
        u_durs_host.xfer(1'b1, 1'b1, 3'h7, 8'h00, rq);
        rc(3'h7, 8'ha5, "deselected");
        $display("test normal done");
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        chk("divisor", div_o, 16'h1234);
        rc(3'h1, 8'h12, "divisor_high");
        chk("irq_enable", {8'h00, ier_o}, 16'h000f);
        $display("test divisor done");
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        for (i = 4; i < 8; i = i + 1)
            wr(i[2:0], 8'(8'h11 * i));
        chk("resume_one", {8'h00, r1_o}, 16'h0044);
        chk("pause_two", {8'h00, p2_o}, 16'h0077);
        chk("resume_two", {8'h00, r2_o}, 16'h0055);
        chk("pause_one", {8'h00, p1_o}, 16'h0066);
        chk("modem_control", {8'h00, mcr_o}, 16'h001f);
        rc(3'h2, 8'h10, "enhanced");
        rc(3'h0, 8'h34, "divisor_low");
        $display("test enhanced done");
        wr(3'h3, 8'h03);
        wr(3'h1, 8'hff);
        wr(3'h4, 8'hc0);
        wr(3'h2, 8'h30);
        chk("irq_enable", {8'h00, ier_o}, 16'h00ff);
        chk("modem_control", {8'h00, mcr_o}, 16'h00c0);
        chk("fifo_control", {8'h00, fcr_o}, 16'h0030);
        wr(3'h6, 8'h66);
        wr(3'h7, 8'h78);
        chk("flow_threshold", {8'h00, tce_o}, 16'h0066);
        rc(3'h6, 8'h66, "flow_threshold");
        sel_a_b <= 1'b0;
        sel_b_b <= 1'b0;
        wr(3'h4, 8'hc4);
        rc(3'h7, 8'h21, "ready_summary");
        rdy_rx <= 2'b01;
        rc(3'h7, 8'h11, "ready_summary");
        wr(3'h4, 8'hd4);
        rc(3'h7, 8'h78, "trigger_level");
        chk("trigger_level", {8'h00, thr_o}, 16'h0078);
        $display("test threshold done");
        conclude;
    end
endmodule
